// ### hw/hmdb_pkg.sv
// Package of the host message and doorbell register block.
// Assumes both access ports run on the one device clock.
package hmdb_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [31:0] HMDB_WIN_BASE    = 32'h0000_1300;
    localparam logic [31:0] HMDB_WIN_BYTES   = 32'h0000_0050;
    localparam logic [31:0] HMDB_IN_MSG0     = 32'h0000_1310;
    localparam logic [31:0] HMDB_IN_MSG1     = 32'h0000_1314;
    localparam logic [31:0] HMDB_OUT_MSG0    = 32'h0000_1318;
    localparam logic [31:0] HMDB_OUT_MSG1    = 32'h0000_131c;
    localparam logic [31:0] HMDB_IN_DB       = 32'h0000_1320;
    localparam logic [31:0] HMDB_IN_STAT     = 32'h0000_1324;
    localparam logic [31:0] HMDB_IN_MASK     = 32'h0000_1328;
    localparam logic [31:0] HMDB_OUT_DB      = 32'h0000_132c;
    localparam logic [31:0] HMDB_OUT_STAT    = 32'h0000_1330;
    localparam logic [31:0] HMDB_OUT_MASK    = 32'h0000_1334;

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int          HMDB_NMI_BIT     = 31;
    localparam int          HMDB_IS_DB_BIT   = 2;
    localparam int          HMDB_IS_NMI_BIT  = 3;
    localparam int          HMDB_OS_MSG_BIT  = 0;
    localparam int          HMDB_OS_DB_BIT   = 1;
    localparam logic [31:0] HMDB_RST_WORD    = 32'h0000_0000;
    localparam logic [3:0]  HMDB_RST_PINS_N  = 4'hf;
    localparam logic [3:0]  HMDB_IDX_NONE    = 4'hf;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef struct packed {
        logic        vld;
        logic        wr;
        logic [31:0] addr;
        logic [31:0] wdata;
    } hmdb_req_t;

    typedef struct packed {
        logic        vld;
        logic [31:0] rdata;
    } hmdb_rsp_t;

endpackage : hmdb_pkg

// ### hw/hmdb_regs.sv
// Message and doorbell register block between a PCI agent and the local core.
// Assumes both request ports are driven by logic on MCLK_IN, one request a cycle.
//
// Functional notes
// - Registers reachable from PCI window (first 80 bytes) and core bus.
// - Ten 32-bit registers decoded at local addresses 1310h through 1334h.
// - Inbound message write sets status and core interrupt unless masked.
// - Inbound status bit 0 for message 0, bit 1 for message 1.
// - Outbound message write sets outbound status and PCI interrupt unless masked.
// - Inbound doorbell bit 31 drives the core NMI request.
// - Other doorbell bits drive the general core interrupt unless masked.
// - Inbound doorbell bits set only from PCI, cleared only from the core.
// - All inbound sources go to general line except NMI doorbell.
// - Status bit 3 mirrors doorbell bit 31 and clears with it.
// - Status bit 2 set while any non-NMI doorbell bit is set.
// - Inbound mask bits suppress the matching core interrupts.
// - Doorbell status bits are read-only in inbound status.
// - Core writes 1 to clear an inbound message status bit.
// - Doorbell cleared by writing 1; zeros leave bits unchanged.
// - PCI agent writes 1 to clear outbound message status.
// - PCI interrupt driven on the pin chosen by the pin setting.
`timescale 1ns/1ps

module hmdb_regs
    import hmdb_pkg::*;
(
    // Clock and reset
    input  wire logic        MCLK_IN,
    input  wire logic        RST_IN,
    // PCI side, address is the offset within the inbound window
    input  wire hmdb_req_t   PCI_REQ_IN,
    output hmdb_rsp_t        PCI_RSP_OUT,
    // Local core side, address is the local bus address
    input  wire hmdb_req_t   CORE_REQ_IN,
    output hmdb_rsp_t        CORE_RSP_OUT,
    // Interrupts
    input  wire logic [1:0]  INT_PIN_SEL_IN,
    output logic             CORE_IRQ_OUT,
    output logic             CORE_NMI_OUT,
    output logic [3:0]       PCI_INT_N_OUT
);

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    // Index 0..9 follows the register order; anything else is unmapped.
    function automatic logic [3:0] reg_index(input logic [31:0] a);
        logic [31:0] d;
        d = a - HMDB_IN_MSG0;
        if (a < HMDB_IN_MSG0 || a > HMDB_OUT_MASK || a[1:0] != 2'b00) begin
            reg_index = HMDB_IDX_NONE;
        end else begin
            reg_index = d[5:2];
        end
    endfunction : reg_index

    logic [31:0] pci_local;
    logic [3:0]  pci_idx;
    logic [3:0]  core_idx;
    logic        pci_wr;
    logic        core_wr;

    always_comb begin
        pci_local = PCI_REQ_IN.addr + HMDB_WIN_BASE;
        if (PCI_REQ_IN.addr < HMDB_WIN_BYTES) begin
            pci_idx = reg_index(pci_local);
        end else begin
            pci_idx = HMDB_IDX_NONE;
        end
        core_idx = reg_index(CORE_REQ_IN.addr);
        pci_wr   = PCI_REQ_IN.vld & PCI_REQ_IN.wr;
        core_wr  = CORE_REQ_IN.vld & CORE_REQ_IN.wr;
    end

    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    logic [31:0] msg_q [4];
    logic [31:0] msg_d [4];
    logic [31:0] idb_q, idb_d;
    logic [31:0] odb_q, odb_d;
    logic [1:0]  in_msg_st_q, in_msg_st_d;
    logic        out_msg_st_q, out_msg_st_d;
    logic [3:0]  imask_q, imask_d;
    logic [1:0]  omask_q, omask_d;
    logic [31:0] istat;
    logic [31:0] ostat;

    always_comb begin
        istat = HMDB_RST_WORD;
        istat[1:0] = in_msg_st_q;
        istat[HMDB_IS_DB_BIT]  = |idb_q[HMDB_NMI_BIT-1:0];
        istat[HMDB_IS_NMI_BIT] = idb_q[HMDB_NMI_BIT];
        ostat = HMDB_RST_WORD;
        ostat[HMDB_OS_MSG_BIT] = out_msg_st_q;
        ostat[HMDB_OS_DB_BIT]  = |odb_q;
    end

    always_comb begin
        for (int k = 0; k < 4; k++) begin
            msg_d[k] = msg_q[k];
            // The core write is applied last, so it wins a same-cycle clash.
            if (pci_wr && pci_idx == 4'(k)) begin
                msg_d[k] = PCI_REQ_IN.wdata;
            end
            if (core_wr && core_idx == 4'(k)) begin
                msg_d[k] = CORE_REQ_IN.wdata;
            end
        end
        // Clears are applied before sets so an event in a clear cycle survives.
        idb_d = idb_q;
        if (core_wr && core_idx == 4'h4) begin
            idb_d = idb_d & ~CORE_REQ_IN.wdata;
        end
        if (pci_wr && pci_idx == 4'h4) begin
            idb_d = idb_d | PCI_REQ_IN.wdata;
        end
        odb_d = odb_q;
        if (pci_wr && pci_idx == 4'h7) begin
            odb_d = odb_d & ~PCI_REQ_IN.wdata;
        end
        if (core_wr && core_idx == 4'h7) begin
            odb_d = odb_d | CORE_REQ_IN.wdata;
        end
        in_msg_st_d = in_msg_st_q;
        if (core_wr && core_idx == 4'h5) begin
            in_msg_st_d = in_msg_st_d & ~CORE_REQ_IN.wdata[1:0];
        end
        for (int k = 0; k < 2; k++) begin
            if ((pci_wr && pci_idx == 4'(k)) || (core_wr && core_idx == 4'(k))) begin
                in_msg_st_d[k] = 1'b1;
            end
        end
        out_msg_st_d = out_msg_st_q;
        if (pci_wr && pci_idx == 4'h8 && PCI_REQ_IN.wdata[HMDB_OS_MSG_BIT]) begin
            out_msg_st_d = 1'b0;
        end
        if ((pci_wr && (pci_idx == 4'h2 || pci_idx == 4'h3)) ||
            (core_wr && (core_idx == 4'h2 || core_idx == 4'h3))) begin
            out_msg_st_d = 1'b1;
        end
        imask_d = imask_q;
        omask_d = omask_q;
        if (pci_wr && pci_idx == 4'h6) begin
            imask_d = PCI_REQ_IN.wdata[3:0];
        end
        if (core_wr && core_idx == 4'h6) begin
            imask_d = CORE_REQ_IN.wdata[3:0];
        end
        if (pci_wr && pci_idx == 4'h9) begin
            omask_d = PCI_REQ_IN.wdata[1:0];
        end
        if (core_wr && core_idx == 4'h9) begin
            omask_d = CORE_REQ_IN.wdata[1:0];
        end
    end

    always_ff @(posedge MCLK_IN) begin
        if (RST_IN) begin
            for (int k = 0; k < 4; k++) begin
                msg_q[k] <= HMDB_RST_WORD;
            end
            idb_q        <= HMDB_RST_WORD;
            odb_q        <= HMDB_RST_WORD;
            in_msg_st_q  <= '0;
            out_msg_st_q <= 1'b0;
            imask_q      <= '0;
            omask_q      <= '0;
        end else begin
            msg_q        <= msg_d;
            idb_q        <= idb_d;
            odb_q        <= odb_d;
            in_msg_st_q  <= in_msg_st_d;
            out_msg_st_q <= out_msg_st_d;
            imask_q      <= imask_d;
            omask_q      <= omask_d;
        end
    end

    // ------------------------------------------------------------
    // Read path and interrupt outputs
    // ------------------------------------------------------------
    // Reserved and unmapped locations read as zero; writes to them are dropped.
    function automatic logic [31:0] read_reg(input logic [3:0] idx);
        if (idx < 4'h4) begin
            read_reg = msg_q[idx[1:0]];
        end else if (idx == 4'h4) begin
            read_reg = idb_q;
        end else if (idx == 4'h5) begin
            read_reg = istat;
        end else if (idx == 4'h6) begin
            read_reg = {28'h000_0000, imask_q};
        end else if (idx == 4'h7) begin
            read_reg = odb_q;
        end else if (idx == 4'h8) begin
            read_reg = ostat;
        end else if (idx == 4'h9) begin
            read_reg = {30'h0000_0000, omask_q};
        end else begin
            read_reg = HMDB_RST_WORD;
        end
    endfunction : read_reg

    hmdb_rsp_t   pci_rsp_q, pci_rsp_d;
    hmdb_rsp_t   core_rsp_q, core_rsp_d;
    logic        irq_q, irq_d;
    logic        nmi_q, nmi_d;
    logic [3:0]  pins_n_q, pins_n_d;
    logic        pci_int;

    always_comb begin
        pci_rsp_d.vld    = PCI_REQ_IN.vld & ~PCI_REQ_IN.wr;
        pci_rsp_d.rdata  = pci_rsp_d.vld ? read_reg(pci_idx) : HMDB_RST_WORD;
        core_rsp_d.vld   = CORE_REQ_IN.vld & ~CORE_REQ_IN.wr;
        core_rsp_d.rdata = core_rsp_d.vld ? read_reg(core_idx) : HMDB_RST_WORD;
        irq_d   = |(istat[2:0] & ~imask_q[2:0]);
        nmi_d   = istat[HMDB_IS_NMI_BIT] & ~imask_q[HMDB_IS_NMI_BIT];
        pci_int = |(ostat[1:0] & ~omask_q);
        pins_n_d = HMDB_RST_PINS_N;
        pins_n_d[INT_PIN_SEL_IN] = ~pci_int;
    end

    always_ff @(posedge MCLK_IN) begin
        if (RST_IN) begin
            pci_rsp_q  <= '0;
            core_rsp_q <= '0;
            irq_q      <= 1'b0;
            nmi_q      <= 1'b0;
            pins_n_q   <= HMDB_RST_PINS_N;
        end else begin
            pci_rsp_q  <= pci_rsp_d;
            core_rsp_q <= core_rsp_d;
            irq_q      <= irq_d;
            nmi_q      <= nmi_d;
            pins_n_q   <= pins_n_d;
        end
    end

    assign PCI_RSP_OUT   = pci_rsp_q;
    assign CORE_RSP_OUT  = core_rsp_q;
    assign CORE_IRQ_OUT  = irq_q;
    assign CORE_NMI_OUT  = nmi_q;
    assign PCI_INT_N_OUT = pins_n_q;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    property p_msg0_status;
        @(posedge MCLK_IN) disable iff (RST_IN)
        (core_wr && core_idx == 4'h0) |=> in_msg_st_q[0];
    endproperty
    a_msg0_status: assert property (p_msg0_status) else $error("message 0 status not set");

    property p_msg1_irq;
        @(posedge MCLK_IN) disable iff (RST_IN)
        (pci_wr && pci_idx == 4'h1 && !imask_q[1] && !imask_d[1]) |-> ##2 CORE_IRQ_OUT;
    endproperty
    a_msg1_irq: assert property (p_msg1_irq) else $error("message 1 irq missing");

    property p_irq_masked;
        @(posedge MCLK_IN) disable iff (RST_IN)
        ((istat[2:0] & ~imask_q[2:0]) == 3'h0) |=> !CORE_IRQ_OUT;
    endproperty
    a_irq_masked: assert property (p_irq_masked) else $error("masked irq asserted");

    property p_nmi_follow;
        @(posedge MCLK_IN) disable iff (RST_IN)
        (idb_q[HMDB_NMI_BIT] && !imask_q[3]) |=> CORE_NMI_OUT;
    endproperty
    a_nmi_follow: assert property (p_nmi_follow) else $error("nmi not raised");

    property p_core_no_set;
        @(posedge MCLK_IN) disable iff (RST_IN)
        !(pci_wr && pci_idx == 4'h4) |=> ((idb_q & ~$past(idb_q)) == 32'h0000_0000);
    endproperty
    a_core_no_set: assert property (p_core_no_set) else $error("doorbell set by core");

    property p_pci_no_clear;
        @(posedge MCLK_IN) disable iff (RST_IN)
        !(core_wr && core_idx == 4'h4) |=> ((~idb_q & $past(idb_q)) == 32'h0000_0000);
    endproperty
    a_pci_no_clear: assert property (p_pci_no_clear) else $error("doorbell cleared by pci");

    property p_db_status_ro;
        @(posedge MCLK_IN) disable iff (RST_IN)
        (core_wr && core_idx == 4'h5 && !pci_wr) |=> $stable(istat[3:2]);
    endproperty
    a_db_status_ro: assert property (p_db_status_ro) else $error("doorbell status cleared");

    property p_msg_clear;
        @(posedge MCLK_IN) disable iff (RST_IN)
        (core_wr && core_idx == 4'h5 && CORE_REQ_IN.wdata[0] && !(pci_wr && pci_idx == 4'h0))
        |=> !in_msg_st_q[0];
    endproperty
    a_msg_clear: assert property (p_msg_clear) else $error("message status not cleared");

    property p_out_pin;
        @(posedge MCLK_IN) disable iff (RST_IN)
        (core_wr && core_idx == 4'h2 && !omask_q[0] && !pci_wr) ##1 !pci_wr
        ##1 $stable(INT_PIN_SEL_IN) |-> !PCI_INT_N_OUT[INT_PIN_SEL_IN];
    endproperty
    a_out_pin: assert property (p_out_pin) else $error("pci pin not asserted");

    property p_msg_store;
        @(posedge MCLK_IN) disable iff (RST_IN)
        (pci_wr && pci_idx == 4'h0 && !(core_wr && core_idx == 4'h0))
        |=> msg_q[0] == $past(PCI_REQ_IN.wdata);
    endproperty
    a_msg_store: assert property (p_msg_store) else $error("message word lost");

endmodule : hmdb_regs

// ### sim/hmdb_pci_agent.sv
// PCI agent model that reaches the registers through the inbound window.
// Assumes window offsets and one request per clock on the device clock.
`timescale 1ns/1ps

module hmdb_pci_agent
    import hmdb_pkg::*;
(
    // Clock and read answer
    input  wire logic      clk_in,
    input  wire hmdb_rsp_t rsp_in,
    // Requests into the window
    output hmdb_req_t      req_out
);
    initial req_out = '0;

    // Idle fields show the inverse of the last request so stale values never match.
    task automatic release_bus();
        req_out = {1'b0, ~req_out[64:0]};
    endtask : release_bus

    // Only offsets the caller names are touched; reserved ones only on purpose.
    task automatic wr(input logic [31:0] off, input logic [31:0] data);
        req_out = '{vld: 1'b1, wr: 1'b1, addr: off, wdata: data};
        @(posedge clk_in);
        #1;
        release_bus();
        @(posedge clk_in);
        #1;
    endtask : wr

    task automatic rd(input logic [31:0] off, output logic [31:0] data);
        req_out = '{vld: 1'b1, wr: 1'b0, addr: off, wdata: 32'h0000_0000};
        @(posedge clk_in);
        #1;
        // The answer stands only until the next edge, so it is taken now.
        data = (rsp_in.vld === 1'b1) ? rsp_in.rdata : 32'hxxxx_xxxx;
        release_bus();
        @(posedge clk_in);
        #1;
    endtask : rd
endmodule : hmdb_pci_agent

// ### sim/tb_top.sv
// Self-checking bench of the message and doorbell register block.
// Assumes the PCI agent model on the PCI port and core accesses from here.
`timescale 1ns/1ps

module tb_top
    import hmdb_pkg::*;
;
    logic       mclk;
    logic       rst;
    hmdb_req_t  core_req;
    hmdb_rsp_t  core_rsp;
    hmdb_req_t  pci_req;
    hmdb_rsp_t  pci_rsp;
    logic [1:0] pin_sel;
    logic       irq;
    logic       nmi;
    logic [3:0] pins_n;
    int         n_fail;
    int         samples_checked;
    int         cyc;
    logic [31:0] d;

    hmdb_regs i_hmdb_regs (.MCLK_IN(mclk), .RST_IN(rst), .PCI_REQ_IN(pci_req),
        .PCI_RSP_OUT(pci_rsp), .CORE_REQ_IN(core_req), .CORE_RSP_OUT(core_rsp),
        .INT_PIN_SEL_IN(pin_sel), .CORE_IRQ_OUT(irq), .CORE_NMI_OUT(nmi),
        .PCI_INT_N_OUT(pins_n));

    hmdb_pci_agent i_hmdb_pci_agent (.clk_in(mclk), .rsp_in(pci_rsp), .req_out(pci_req));

    // ------------------------------------------------------------
    // Access tasks
    // ------------------------------------------------------------
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : tick

    task automatic core_wr(input logic [31:0] a, input logic [31:0] v);
        core_req = '{vld: 1'b1, wr: 1'b1, addr: a, wdata: v};
        tick(1);
        core_req = {1'b0, ~core_req[64:0]};
        tick(1);
    endtask : core_wr

    task automatic core_rd(input logic [31:0] a, output logic [31:0] v);
        core_req = '{vld: 1'b1, wr: 1'b0, addr: a, wdata: 32'h0000_0000};
        tick(1);
        v = (core_rsp.vld === 1'b1) ? core_rsp.rdata : 32'hxxxx_xxxx;
        core_req = {1'b0, ~core_req[64:0]};
        tick(1);
    endtask : core_rd

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task automatic complete_run();
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : complete_run

    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    // A hang costs a mismatch; the sequence needs well under a thousand cycles.
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 3000) begin
            n_fail++;
            complete_run();
        end
    end

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial begin
        rst = 1'b1;
        core_req = '0;
        pin_sel = 2'd0;
        n_fail = 0;
        samples_checked = 0;
        cyc = 0;
        d = '0;
        repeat (16) @(posedge mclk);
        #1;
        rst = 1'b0;
        for (int k = 0; k < 10; k++) begin
            core_rd(HMDB_IN_MSG0 + 32'(4 * k), d);
            check("core reset word", d, HMDB_RST_WORD);
            i_hmdb_pci_agent.rd(32'h0000_0010 + 32'(4 * k), d);
            check("pci reset word", d, HMDB_RST_WORD);
        end
        check("pins reset", {28'h0, pins_n}, {28'h0, HMDB_RST_PINS_N});
        i_hmdb_pci_agent.wr(32'h0000_0014, 32'ha5a5_0f0f);
        tick(2);
        check("irq msg1", {31'h0, irq}, 32'h0000_0001);
        core_rd(HMDB_IN_STAT, d);
        check("status msg1", d, 32'h0000_0002);
        core_rd(HMDB_IN_MSG1, d);
        check("in msg1", d, 32'ha5a5_0f0f);
        core_wr(HMDB_IN_STAT, 32'h0000_0002);
        tick(2);
        check("irq cleared", {31'h0, irq}, 32'h0000_0000);
        core_wr(HMDB_IN_MASK, 32'h0000_0001);
        i_hmdb_pci_agent.wr(32'h0000_0010, 32'h1234_5678);
        tick(2);
        check("irq masked", {31'h0, irq}, 32'h0000_0000);
        core_rd(HMDB_IN_STAT, d);
        check("status msg0", d, 32'h0000_0001);
        core_wr(HMDB_IN_STAT, 32'h0000_0001);
        core_wr(HMDB_IN_MASK, 32'h0000_0000);
        i_hmdb_pci_agent.wr(32'h0000_0020, 32'h0000_0005);
        i_hmdb_pci_agent.wr(32'h0000_0020, 32'h0000_0000);
        core_wr(HMDB_IN_STAT, 32'h0000_000f);
        tick(2);
        check("irq doorbell", {31'h0, irq}, 32'h0000_0001);
        core_rd(HMDB_IN_STAT, d);
        check("status doorbell", d, 32'h0000_0004);
        core_wr(HMDB_IN_DB, 32'h0000_0004);
        core_rd(HMDB_IN_DB, d);
        check("doorbell partial", d, 32'h0000_0001);
        i_hmdb_pci_agent.wr(32'h0000_0020, 32'h0000_0000);
        core_rd(HMDB_IN_STAT, d);
        check("status still set", d, 32'h0000_0004);
        core_wr(HMDB_IN_DB, 32'h0000_0001);
        tick(2);
        check("irq doorbell off", {31'h0, irq}, 32'h0000_0000);
        i_hmdb_pci_agent.wr(32'h0000_0020, 32'h8000_0000);
        tick(2);
        check("nmi set", {30'h0, nmi, irq}, 32'h0000_0002);
        core_rd(HMDB_IN_STAT, d);
        check("status nmi", d, 32'h0000_0008);
        core_wr(HMDB_IN_DB, 32'h8000_0000);
        tick(2);
        check("nmi clear", {30'h0, nmi, irq}, 32'h0000_0000);
        core_wr(HMDB_IN_DB, 32'h0000_0002);
        core_rd(HMDB_IN_DB, d);
        check("core cannot set", d, 32'h0000_0000);
        for (int s = 0; s < 4; s++) begin
            pin_sel = 2'(s);
            core_wr(HMDB_OUT_MSG0, 32'hc0de_0000 + 32'(s));
            tick(2);
            check("pin low", {28'h0, pins_n}, {28'h0, ~(4'h1 << s)});
            i_hmdb_pci_agent.rd(32'h0000_0018, d);
            check("out msg0", d, 32'hc0de_0000 + 32'(s));
            i_hmdb_pci_agent.wr(32'h0000_0030, 32'h0000_0001);
            tick(2);
            check("pin released", {28'h0, pins_n}, 32'h0000_000f);
        end
        core_wr(HMDB_OUT_MASK, 32'h0000_0001);
        core_wr(HMDB_OUT_MSG1, 32'h0bad_f00d);
        tick(2);
        check("pin masked", {28'h0, pins_n}, 32'h0000_000f);
        core_wr(HMDB_OUT_MASK, 32'h0000_0000);
        tick(2);
        check("pin unmasked", {28'h0, pins_n}, 32'h0000_0007);
        i_hmdb_pci_agent.wr(32'h0000_0030, 32'h0000_0001);
        core_wr(HMDB_OUT_DB, 32'h0000_0003);
        tick(2);
        check("pin doorbell", {28'h0, pins_n}, 32'h0000_0007);
        i_hmdb_pci_agent.rd(32'h0000_0030, d);
        check("out status", d, 32'h0000_0002);
        i_hmdb_pci_agent.wr(32'h0000_002c, 32'h0000_0003);
        tick(2);
        check("pin doorbell off", {28'h0, pins_n}, 32'h0000_000f);
        i_hmdb_pci_agent.rd(32'h0000_0050, d);
        check("pci unmapped", d, 32'h0000_0000);
        core_rd(32'h0000_1338, d);
        check("core unmapped", d, 32'h0000_0000);
        complete_run();
    end
endmodule : tb_top
